// ===== hdl/clk_sel_pkg.sv
// Package: register map, field layout, timing counts and types for the sample clock select
//
// Contract
// - In mixed multiphase mode every sample goes to the trace control on the master clock expression.
// - In mixed multiphase mode each section is set to external or internal clocking on its own.
// - An external section whose expression equals the master expression captures on the master clock.
// - An external section with its own expression loads on it and is handed over on the master clock.
// - An internally clocked section samples at the programmed internal period.
// - In internal extended mode all three sections can sample together at the fast interval.
// - In internal extended mode each section picks the fast interval or the master rate.
// - In internal extended mode the master clock comes from the internal period, legal 20 ns to 160 ms.
// - The trace control is never clocked faster than once per 20 ns.
// - Fast sections may be offset by a sample or two at trace decisions, elsewhere keep their rate.
// - Sections running at the same internal rate stay aligned with no skew.
// - The master expression is true when all AND clocks are true or any OR clock is true.
// - Sample clock inputs are edge sensitive.
// - Each master sample adds one to the level sample counter while delay by clocks is on.
package clk_sel_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SECT   = 8'h04;
    localparam logic [7:0] ADDR_MEXPR  = 8'h08;
    localparam logic [7:0] ADDR_AEXPR  = 8'h0C;
    localparam logic [7:0] ADDR_BEXPR  = 8'h10;
    localparam logic [7:0] ADDR_CEXPR  = 8'h14;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_COUNT  = 8'h20;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_STOP_BIT  = 2;
    localparam int CTRL_DELAY_BIT = 3;
    localparam int SECT_EXT_LSB   = 0;
    localparam int SECT_FOL_LSB   = 4;
    localparam int PER_MULT_LSB   = 0;
    localparam int PER_UNIT_LSB   = 4;
    localparam int EXPR_W         = 12;
    localparam int SECT_W         = 16;
    localparam int NPIN           = 6;

    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [2:0]  EXT_RST    = 3'h0;
    localparam logic [2:0]  FOL_RST    = 3'h0;
    localparam logic [11:0] EXPR_RST   = 12'h000;
    localparam logic [5:0]  PERIOD_RST = 6'h01;

    // Clock field encodings
    localparam logic [1:0] FLD_OFF  = 2'h0;
    localparam logic [1:0] FLD_HIGH = 2'h1;
    localparam logic [1:0] FLD_LOW  = 2'h2;

    // Period units
    localparam logic [1:0] UNIT_NS = 2'h0;
    localparam logic [1:0] UNIT_US = 2'h1;
    localparam logic [1:0] UNIT_MS = 2'h2;
    localparam logic [31:0] STEP_NS_NS = 32'h0000000A;
    localparam logic [31:0] STEP_US_NS = 32'h00002710;
    localparam logic [31:0] STEP_MS_NS = 32'h00989680;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS        = 100;
    localparam int FAST_NS       = 10;
    localparam int MIN_TRACE_NS  = 20;
    localparam int MAX_PERIOD_NS = 160000000;
    localparam int FAST_CYC      = (FAST_NS / CLK_NS) < 1 ? 1 : FAST_NS / CLK_NS;
    localparam int MIN_TRACE_CYC = (MIN_TRACE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PER_CNT_W     = 21;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [SECT_W-1:0] c;
        logic [SECT_W-1:0] b;
        logic [SECT_W-1:0] a;
    } sample_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } acq_state_t;

endpackage : clk_sel_pkg

// ===== hdl/sample_buf.sv
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module sample_buf #(
    parameter int W     = 48,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Fill side
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    // Drain side
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign o_ready = cnt_q != (AW+1)'(DEPTH);
    assign o_valid = cnt_q != '0;
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_q[rp_q];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + AW'(1);
            if (pop) rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) mem_q[wp_q] <= i_data;
    end
endmodule : sample_buf

// ===== hdl/acq_clock_select.sv
// Sample clock selection for three 16-input sections, with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module acq_clock_select (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // AHB-Lite slave
    input  wire logic                 i_hsel,
    input  wire logic [31:0]          i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic                 i_hready,
    input  wire logic [31:0]          i_hwdata,
    output logic [31:0]               o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    // Target pins
    input  wire logic [5:0]           i_clk_pins,
    input  wire logic [47:0]          i_data_pins,
    // Trace control stream
    output logic                      o_trace_valid,
    input  wire logic                 i_trace_ready,
    output clk_sel_pkg::sample_t      o_trace_sample,
    // Status
    output logic                      o_running
);
    // ****************************************
    // Helpers
    // ****************************************
    // Edge-sensitive evaluation: fields 0..2 are AND clocks, 3..5 OR clocks
    function automatic logic expr_true(input logic [11:0] e, input logic [5:0] rise,
                                       input logic [5:0] fall);
        logic       and_ok;
        logic       and_any;
        logic       or_hit;
        logic       hit;
        logic [1:0] f;
        and_ok  = 1'b1;
        and_any = 1'b0;
        or_hit  = 1'b0;
        hit     = 1'b0;
        f       = 2'h0;
        for (int i = 0; i < 6; i++) begin
            f   = e[2*i +: 2];
            hit = (f == clk_sel_pkg::FLD_HIGH && rise[i]) ||
                  (f == clk_sel_pkg::FLD_LOW && fall[i]);
            if (i < 3) begin
                if (f != clk_sel_pkg::FLD_OFF) begin
                    and_any = 1'b1;
                    if (!hit) and_ok = 1'b0;
                end
            end else if (hit) begin
                or_hit = 1'b1;
            end
        end
        return (and_any && and_ok) || or_hit;
    endfunction : expr_true

    function automatic logic per_legal(input logic [5:0] p);
        logic [1:0] u;
        u = p[clk_sel_pkg::PER_UNIT_LSB +: 2];
        return (u != 2'h3) && !(u == clk_sel_pkg::UNIT_NS && p[3:0] == 4'h0);
    endfunction : per_legal

    function automatic logic [20:0] per_cycles(input logic [5:0] p);
        logic [31:0] step;
        logic [31:0] ns;
        logic [31:0] cyc;
        step = clk_sel_pkg::STEP_NS_NS;
        case (p[clk_sel_pkg::PER_UNIT_LSB +: 2])
            clk_sel_pkg::UNIT_US: step = clk_sel_pkg::STEP_US_NS;
            clk_sel_pkg::UNIT_MS: step = clk_sel_pkg::STEP_MS_NS;
            default:              step = clk_sel_pkg::STEP_NS_NS;
        endcase
        ns  = (32'(p[clk_sel_pkg::PER_MULT_LSB +: 4]) + 32'h1) * step;
        cyc = ns / 32'(clk_sel_pkg::CLK_NS);
        return (cyc == 32'h0) ? 21'h000001 : cyc[20:0];
    endfunction : per_cycles

    // ****************************************
    // Pin synchronisers and edges
    // ****************************************
    logic [53:0] pin1_q;
    logic [53:0] pin2_q;
    logic [5:0]  clk3_q;
    logic [5:0]  rise;
    logic [5:0]  fall;
    logic [47:0] data_now;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin1_q <= '0;
            pin2_q <= '0;
            clk3_q <= '0;
        end else begin
            pin1_q <= {i_clk_pins, i_data_pins};
            pin2_q <= pin1_q;
            clk3_q <= pin2_q[53:48];
        end
    end

    assign rise     = pin2_q[53:48] & ~clk3_q;
    assign fall     = ~pin2_q[53:48] & clk3_q;
    assign data_now = pin2_q[47:0];

    // ****************************************
    // Register file
    // ****************************************
    logic [3:0]  ctrl_q;
    logic [2:0]  ext_q;
    logic [2:0]  fol_q;
    logic [11:0] mexpr_q;
    logic [11:0] sexpr_q [3];
    logic [5:0]  per_q;
    logic        illegal_q;
    logic        overrun_q;
    logic [31:0] count_q;
    logic        wr_pend_q;
    logic [7:0]  waddr_q;
    logic [31:0] rdata_q;
    logic        addr_ok;
    logic        rd_req;
    logic        wr_ctrl;
    logic        wr_per;
    logic        start_pulse;
    logic        stop_pulse;
    logic [31:0] rd_mux;
    logic [7:0]  raddr;

    assign addr_ok     = i_hsel && i_hready && i_htrans[1];
    assign rd_req      = addr_ok && !i_hwrite;
    assign raddr       = i_haddr[7:0];
    assign wr_ctrl     = wr_pend_q && waddr_q == clk_sel_pkg::ADDR_CTRL;
    assign wr_per      = wr_pend_q && waddr_q == clk_sel_pkg::ADDR_PERIOD;
    assign start_pulse = wr_ctrl && i_hwdata[clk_sel_pkg::CTRL_START_BIT];
    assign stop_pulse  = wr_ctrl && i_hwdata[clk_sel_pkg::CTRL_STOP_BIT];

    assign rd_mux = (raddr == clk_sel_pkg::ADDR_CTRL)   ? {28'h0, 2'h0, ctrl_q[3], ctrl_q[0]} :
                    (raddr == clk_sel_pkg::ADDR_SECT)   ? {25'h0, fol_q, 1'b0, ext_q} :
                    (raddr == clk_sel_pkg::ADDR_MEXPR)  ? {20'h0, mexpr_q} :
                    (raddr == clk_sel_pkg::ADDR_AEXPR)  ? {20'h0, sexpr_q[0]} :
                    (raddr == clk_sel_pkg::ADDR_BEXPR)  ? {20'h0, sexpr_q[1]} :
                    (raddr == clk_sel_pkg::ADDR_CEXPR)  ? {20'h0, sexpr_q[2]} :
                    (raddr == clk_sel_pkg::ADDR_PERIOD) ? {26'h0, per_q} :
                    (raddr == clk_sel_pkg::ADDR_STATUS) ? {29'h0, overrun_q, illegal_q,
                                                           o_running} :
                    (raddr == clk_sel_pkg::ADDR_COUNT)  ? count_q : 32'h0;

    assign o_hrdata    = rdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 8'h00;
            rdata_q   <= 32'h0;
        end else begin
            wr_pend_q <= addr_ok && i_hwrite;
            waddr_q   <= raddr;
            if (rd_req) rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q     <= clk_sel_pkg::CTRL_RST;
            ext_q      <= clk_sel_pkg::EXT_RST;
            fol_q      <= clk_sel_pkg::FOL_RST;
            mexpr_q    <= clk_sel_pkg::EXPR_RST;
            sexpr_q[0] <= clk_sel_pkg::EXPR_RST;
            sexpr_q[1] <= clk_sel_pkg::EXPR_RST;
            sexpr_q[2] <= clk_sel_pkg::EXPR_RST;
            per_q      <= clk_sel_pkg::PERIOD_RST;
            illegal_q  <= 1'b0;
        end else if (wr_pend_q) begin
            if (wr_ctrl) ctrl_q <= {i_hwdata[3], 2'h0, i_hwdata[0]};
            if (waddr_q == clk_sel_pkg::ADDR_SECT) begin
                ext_q <= i_hwdata[clk_sel_pkg::SECT_EXT_LSB +: 3];
                fol_q <= i_hwdata[clk_sel_pkg::SECT_FOL_LSB +: 3];
            end
            if (waddr_q == clk_sel_pkg::ADDR_MEXPR) mexpr_q <= i_hwdata[11:0];
            if (waddr_q == clk_sel_pkg::ADDR_AEXPR) sexpr_q[0] <= i_hwdata[11:0];
            if (waddr_q == clk_sel_pkg::ADDR_BEXPR) sexpr_q[1] <= i_hwdata[11:0];
            if (waddr_q == clk_sel_pkg::ADDR_CEXPR) sexpr_q[2] <= i_hwdata[11:0];
            // Illegal periods are refused; the old period stays
            if (wr_per && per_legal(i_hwdata[5:0])) per_q <= i_hwdata[5:0];
            if (wr_per) illegal_q <= !per_legal(i_hwdata[5:0]);
        end
    end

    // ****************************************
    // Acquisition control and active copies
    // ****************************************
    clk_sel_pkg::acq_state_t state_q;
    logic        mode_a_q;
    logic        dly_a_q;
    logic [2:0]  ext_a_q;
    logic [2:0]  fol_a_q;
    logic [11:0] mexpr_a_q;
    logic [11:0] sexpr_a_q [3];
    logic [20:0] per_cyc_a_q;
    logic [20:0] pcnt_q;
    logic        fresh;

    assign o_running = state_q == clk_sel_pkg::ST_RUN;
    // A start gives every section a first sample, so no word carries one from before the run
    assign fresh     = start_pulse && !o_running;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q      <= clk_sel_pkg::ST_IDLE;
            mode_a_q     <= 1'b0;
            dly_a_q      <= 1'b0;
            ext_a_q      <= clk_sel_pkg::EXT_RST;
            fol_a_q      <= clk_sel_pkg::FOL_RST;
            mexpr_a_q    <= clk_sel_pkg::EXPR_RST;
            sexpr_a_q[0] <= clk_sel_pkg::EXPR_RST;
            sexpr_a_q[1] <= clk_sel_pkg::EXPR_RST;
            sexpr_a_q[2] <= clk_sel_pkg::EXPR_RST;
            per_cyc_a_q  <= 21'h000001;
        end else begin
            case (state_q)
                clk_sel_pkg::ST_IDLE: begin
                    if (start_pulse) begin
                        // Selections are latched only here, never mid-capture
                        state_q      <= clk_sel_pkg::ST_RUN;
                        mode_a_q     <= i_hwdata[clk_sel_pkg::CTRL_MODE_BIT];
                        dly_a_q      <= i_hwdata[clk_sel_pkg::CTRL_DELAY_BIT];
                        ext_a_q      <= ext_q;
                        fol_a_q      <= fol_q;
                        mexpr_a_q    <= mexpr_q;
                        sexpr_a_q[0] <= sexpr_q[0];
                        sexpr_a_q[1] <= sexpr_q[1];
                        sexpr_a_q[2] <= sexpr_q[2];
                        per_cyc_a_q  <= per_cycles(per_q);
                    end
                end
                clk_sel_pkg::ST_RUN: begin
                    if (stop_pulse) state_q <= clk_sel_pkg::ST_IDLE;
                end
                default: state_q <= clk_sel_pkg::ST_IDLE;
            endcase
        end
    end

    // One shared period counter keeps equal-rate sections in step
    logic tick_int;
    logic tick_fast;
    logic master_hit;
    logic master_fire;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcnt_q <= 21'h0;
        end else if (!o_running || pcnt_q == per_cyc_a_q - 21'h1) begin
            pcnt_q <= 21'h0;
        end else begin
            pcnt_q <= pcnt_q + 21'h1;
        end
    end

    assign tick_int    = o_running && pcnt_q == 21'h0;
    // The fast interval is below one clock, so the fast rate is one sample per clock
    assign tick_fast   = o_running;
    assign master_hit  = expr_true(mexpr_a_q, rise, fall);
    assign master_fire = o_running && (mode_a_q ? tick_int : master_hit);

    // ****************************************
    // Section sample registers
    // ****************************************
    logic [15:0] sect_q [3];
    logic [2:0]  same;
    logic [2:0]  load;
    logic [15:0] pres [3];

    for (genvar s = 0; s < 3; s++) begin : g_sect
        logic own_hit;
        assign own_hit = expr_true(sexpr_a_q[s], rise, fall);
        assign same[s] = mode_a_q ? fol_a_q[s] : (ext_a_q[s] && sexpr_a_q[s] == mexpr_a_q);
        assign load[s] = !o_running ? 1'b0 :
                         mode_a_q   ? (fol_a_q[s] ? tick_int : tick_fast) :
                         ext_a_q[s] ? (same[s] ? master_fire : own_hit) :
                         tick_int;
        // Direct capture for master-rate sections; buffered value otherwise
        assign pres[s] = same[s] ? data_now[16*s +: 16] : sect_q[s];

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) sect_q[s] <= 16'h0000;
            else if (load[s] || fresh) sect_q[s] <= data_now[16*s +: 16];
        end
    end

    // ****************************************
    // Trace stream and level counter
    // ****************************************
    clk_sel_pkg::sample_t push_data;
    logic                 buf_ready;

    assign push_data = '{c: pres[2], b: pres[1], a: pres[0]};

    sample_buf #(
        .W     (48),
        .DEPTH (2)
    ) u_buf (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_valid (master_fire),
        .o_ready (buf_ready),
        .i_data  (push_data),
        .o_valid (o_trace_valid),
        .i_ready (i_trace_ready),
        .o_data  (o_trace_sample)
    );

    // A master sample that meets a full buffer is lost and flagged; a new start clears it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            overrun_q <= 1'b0;
            count_q   <= 32'h0;
        end else begin
            if (master_fire && !buf_ready) overrun_q <= 1'b1;
            else if (start_pulse) overrun_q <= 1'b0;
            if (start_pulse && !o_running) count_q <= 32'h0;
            else if (master_fire && dly_a_q) count_q <= count_q + 32'h1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_mixed_master;
        master_fire && !mode_a_q |-> master_hit;
    endproperty
    a_mixed_master: assert property (p_mixed_master) else $error("push without master");

    property p_same_direct;
        o_running && !mode_a_q && ext_a_q[1] && same[1] && master_fire
            |=> sect_q[1] == $past(data_now[31:16]);
    endproperty
    a_same_direct: assert property (p_same_direct) else $error("same section missed");

    property p_own_expr;
        o_running && !mode_a_q && ext_a_q[0] && !same[0] && g_sect[0].own_hit
            |-> load[0];
    endproperty
    a_own_expr: assert property (p_own_expr) else $error("own clock ignored");

    property p_int_load;
        $changed(sect_q[2]) |-> $past(load[2] || fresh);
    endproperty
    a_int_load: assert property (p_int_load) else $error("section changed unclocked");

    property p_fast;
        o_running && mode_a_q && !fol_a_q[0] |-> load[0];
    endproperty
    a_fast: assert property (p_fast) else $error("fast section idle");

    property p_legal_per;
        per_legal(per_q);
    endproperty
    a_legal_per: assert property (p_legal_per) else $error("illegal period held");

    property p_spacing;
        master_fire && mode_a_q && per_cyc_a_q > 21'h1 |=> !master_fire;
    endproperty
    a_spacing: assert property (p_spacing) else $error("trace clocked too fast");

    property p_aligned;
        o_running && mode_a_q && fol_a_q == 3'h7 |-> load == 3'h7 || load == 3'h0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("sections skewed");

    property p_count;
        master_fire && dly_a_q && !start_pulse |=> count_q == $past(count_q) + 32'h1;
    endproperty
    a_count: assert property (p_count) else $error("level count missed");

    property p_frozen;
        o_running && !start_pulse |=> $stable(ext_a_q) && $stable(fol_a_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("selection changed mid-run");

    c_mixed: cover property (master_fire && !mode_a_q);
    c_intext: cover property (master_fire && mode_a_q && fol_a_q != 3'h7);
    c_overrun: cover property (master_fire && !buf_ready);
    c_illegal: cover property (wr_per && !per_legal(i_hwdata[5:0]));
endmodule : acq_clock_select

// ===== sim/target_model.sv
// Partner model: the probed target driving sample clock and data pins
`timescale 1ns/1ps
module target_model (
    // Clock
    input  wire logic        i_clk,
    // Target pins
    output logic [5:0]       o_clk_pins,
    output logic [47:0]      o_data_pins
);
    initial begin
        o_clk_pins  = 6'h00;
        o_data_pins = 48'h0000_0000_0000;
    end
    // Data is set well ahead of the edge and held after it, so the
    // synchroniser delay never mixes two words
    task automatic pulse(input logic [47:0] d);
        @(posedge i_clk);
        o_data_pins <= d;
        repeat (4) @(posedge i_clk);
        o_clk_pins <= 6'h08;
        repeat (6) @(posedge i_clk);
        o_clk_pins <= 6'h00;
        repeat (6) @(posedge i_clk);
    endtask : pulse
endmodule : target_model

// ===== sim/acquisition_sample_clock_select_tb_top.sv
// Self-checking bench: register bus master, stream monitor and scoreboard
`timescale 1ns/1ps
module acquisition_sample_clock_select_tb_top;
    logic        i_clk = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [5:0]  clk_pins;
    logic [47:0] data_pins, d, exp_const;
    logic [15:0] prev_a;
    logic        tvalid, tready = 1'b1, rnd_rdy = 1'b0, use_q = 1'b0, running;
    clk_sel_pkg::sample_t tsample;
    logic [47:0] expq[$];
    int          mismatches = 0, checks = 0, got = 0;
    always #50 i_clk = ~i_clk;
    acq_clock_select dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
        .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_clk_pins(clk_pins), .i_data_pins(data_pins), .o_trace_valid(tvalid),
        .i_trace_ready(tready), .o_trace_sample(tsample), .o_running(running));
    target_model model_u (.i_clk(i_clk), .o_clk_pins(clk_pins), .o_data_pins(data_pins));
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // ****************************************
    // Register bus master
    // ****************************************
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, {16'h0000, rd}, {16'h0000, exp});
    endtask : rchk
    // ****************************************
    // Stream scoreboard
    // ****************************************
    always @(posedge i_clk) begin
        tready <= rnd_rdy ? 1'($urandom % 2) : 1'b1;
        if (tvalid === 1'b1 && tready === 1'b1) begin
            got++;
            if (!use_q) chk("sample", tsample, exp_const);
            else if (expq.size() == 0) chk("extra sample", 48'h1, 48'h0);
            else chk("sample", tsample, expq.pop_front());
        end
    end
    initial begin
        // The tests need under a thousand clocks; this allows several times that
        #(5000 * 100);
        mismatches++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hC92D));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        rchk("period reset", clk_sel_pkg::ADDR_PERIOD, 32'h0000_0001);
        rchk("ctrl reset", clk_sel_pkg::ADDR_CTRL, 32'h0000_0000);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, clk_sel_pkg::ADDR_PERIOD, (i == 0) ? 32'h0000_0030 : 32'h0000_0000);
            rchk("illegal flag", clk_sel_pkg::ADDR_STATUS, 32'h0000_0002);
            rchk("period kept", clk_sel_pkg::ADDR_PERIOD, 32'h0000_0001);
        end
        // 10 us: one master sample every 100 clocks
        bus(1'b1, clk_sel_pkg::ADDR_PERIOD, 32'h0000_0010);
        rchk("illegal cleared", clk_sel_pkg::ADDR_STATUS, 32'h0000_0000);
        $display("test registers done");
        // Internal extended mode, A at the fast interval, B and C at master
        exp_const = {$urandom, $urandom};
        model_u.o_data_pins <= exp_const;
        bus(1'b1, clk_sel_pkg::ADDR_SECT, 32'h0000_0060);
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_0009);
        got = 0;
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_000B);
        repeat (250) @(posedge i_clk);
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_000D);
        repeat (8) @(posedge i_clk);
        // Ticks fall 1, 101 and 201 clocks after the start
        chk("words seen", 48'(got), 48'h3);
        rchk("master count", clk_sel_pkg::ADDR_COUNT, 32'(got));
        $display("test internal extended done");
        // Mixed multiphase: master, B and C on the rise of OR clock A, section A on its fall
        for (int s = 0; s < 4; s++)
            bus(1'b1, 8'(clk_sel_pkg::ADDR_MEXPR + 4 * s), (s == 1) ? 32'h80 : 32'h40);
        bus(1'b1, clk_sel_pkg::ADDR_SECT, 32'h0000_0007);
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_0008);
        got = 0;
        use_q = 1'b1;
        rnd_rdy = 1'b1;
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_000A);
        bus(1'b1, clk_sel_pkg::ADDR_SECT, 32'h0000_0000);
        prev_a = exp_const[15:0];
        for (int n = 0; n < 6; n++) begin
            d = {$urandom, $urandom};
            // A shows what its own clock took at the previous pulse
            expq.push_back({d[47:16], prev_a});
            prev_a = d[15:0];
            model_u.pulse(d);
        end
        repeat (10) @(posedge i_clk);
        bus(1'b1, clk_sel_pkg::ADDR_CTRL, 32'h0000_000C);
        repeat (8) @(posedge i_clk);
        chk("words left", 48'(expq.size()), 48'h0);
        rchk("master count", clk_sel_pkg::ADDR_COUNT, 32'h0000_0006);
        $display("test mixed multiphase done");
        report_and_stop();
    end
endmodule : acquisition_sample_clock_select_tb_top
